// File: src/lsec_defines.svh
// Register offsets, field positions, reset values and timing counts for the
// regulator and switch enable configuration block.
// Assumes a 10 MHz system clock.
`ifndef LSEC_DEFINES_SVH
`define LSEC_DEFINES_SVH

// Register offsets
`define LSEC_ADDR_LDO_CONFIG 8'h0B
`define LSEC_ADDR_LOAD_SWITCH_CONFIG 8'h0C

// Regulator config field positions
`define LSEC_LDO_SEQ_MSB 7
`define LSEC_LDO_SEQ_LSB 5
`define LSEC_LDO_PASDSC_BIT 4
`define LSEC_LDO_ACTDSC_BIT 3
`define LSEC_LDO_EN_MSB 2
`define LSEC_LDO_EN_LSB 1
`define LSEC_LDO_MODE_BIT 0

// Switch config field positions
`define LSEC_SW_SEQ_MSB 7
`define LSEC_SW_SEQ_LSB 5
`define LSEC_SW_EN_MSB 2
`define LSEC_SW_EN_LSB 1
`define LSEC_SW_SOFT_BIT 0

// Writable-bit masks; sequencing fields and unused bits are not writable
`define LSEC_LDO_WMASK 8'h1F
`define LSEC_SW_WMASK 8'h07

// Reset values of the writable parts
`define LSEC_LDO_RESET 8'h00
`define LSEC_SW_RESET 8'h00

// Soft-start hold time: 60 ms at 100 ns per cycle
`define LSEC_SOFT_START_MS 60
`define LSEC_CLK_PERIOD_NS 100
`define LSEC_SOFT_START_CYC ((`LSEC_SOFT_START_MS * 1000000) / `LSEC_CLK_PERIOD_NS)

`endif

// File: src/lsec_pkg.sv
// Types shared by the regulator and switch enable configuration block.
// Assumes nothing beyond the defines header.
package lsec_pkg;

	// Three-bit sequencing codes
	typedef enum logic [2:0] {
		LSEC_SEQ_OFF0 = 3'h0,
		LSEC_SEQ_ALWAYS = 3'h1,
		LSEC_SEQ_AT_0 = 3'h2,
		LSEC_SEQ_AT_25 = 3'h3,
		LSEC_SEQ_AT_50 = 3'h4,
		LSEC_SEQ_OFF5 = 3'h5,
		LSEC_SEQ_PIN = 3'h6,
		LSEC_SEQ_REG = 3'h7
	} lsec_seq_t;

	// Two-bit register enable codes
	typedef enum logic [1:0] {
		LSEC_EN_OFF = 2'h0,
		LSEC_EN_ON = 2'h1,
		LSEC_EN_CTRL = 2'h2,
		LSEC_EN_RSVD = 2'h3
	} lsec_en_t;

endpackage : lsec_pkg

// File: src/lsec_enable_decode.sv
// Enable decoder for one output (regulator or switch): turns a sequencing
// code, the boot delay progress and the register enable field into an enable.
// Assumes boot progress flags are monotonic and come from the same clock.
`timescale 1ns/1ps
`include "lsec_defines.svh"
module lsec_enable_decode (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Controls
	input wire logic [2:0] seq_i,
	input wire logic [1:0] en_field_i,
	input wire logic supply_ok_i,
	input wire logic boot_0_i,
	input wire logic boot_25_i,
	input wire logic boot_50_i,
	input wire logic boot_100_i,
	input wire logic pin_en_i,
	input wire logic pin_variant_i,
	input wire logic ctrl_pin_i,
	// Result
	output logic enable_o
);

	// Combinational next value of the enable
	logic next_enable;

	// Decode of the sequencing code
	always_comb begin
		next_enable = 1'b0;
		unique case (lsec_pkg::lsec_seq_t'(seq_i))
			lsec_pkg::LSEC_SEQ_OFF0: next_enable = 1'b0;
			lsec_pkg::LSEC_SEQ_OFF5: next_enable = 1'b0;
			lsec_pkg::LSEC_SEQ_ALWAYS: next_enable = supply_ok_i;
			lsec_pkg::LSEC_SEQ_AT_0: next_enable = boot_0_i;
			lsec_pkg::LSEC_SEQ_AT_25: next_enable = boot_25_i;
			lsec_pkg::LSEC_SEQ_AT_50: next_enable = boot_50_i;
			lsec_pkg::LSEC_SEQ_PIN: next_enable = pin_variant_i & pin_en_i;
			lsec_pkg::LSEC_SEQ_REG: begin
				if (boot_100_i) begin
					unique case (lsec_pkg::lsec_en_t'(en_field_i))
						lsec_pkg::LSEC_EN_OFF: next_enable = 1'b0;
						lsec_pkg::LSEC_EN_ON: next_enable = 1'b1;
						lsec_pkg::LSEC_EN_CTRL: next_enable = ctrl_pin_i;
						// Reserved code holds the output off, the safe choice
						lsec_pkg::LSEC_EN_RSVD: next_enable = 1'b0;
					endcase
				end
			end
		endcase
	end

	// Registered enable; the output is a data output and comes from a flop
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			enable_o <= 1'b0;
		end else begin
			enable_o <= next_enable;
		end
	end

	// Off codes never enable
	property p_off_codes;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(seq_i == 3'h0 || seq_i == 3'h5) |=> !enable_o;
	endproperty
	a_off_codes: assert property (p_off_codes) else $error("enable set under off code");

	// Register control gated by full boot delay
	property p_reg_gate;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(seq_i == 3'h7 && !boot_100_i) |=> !enable_o;
	endproperty
	a_reg_gate: assert property (p_reg_gate) else $error("register enable before full delay");

endmodule : lsec_enable_decode

// File: src/lsec_config.sv
// Regulator and power switch enable configuration block: holds the two
// configuration registers, sequences both enables and times switch soft-start.
// Assumes a byte register port from the device's serial interface, and that
// the boot delay progress and supply presence come from the power-on logic.
//
// Function
// - Sequence field read-only; 000/101 off, 001 supply-on
// - Codes 010/011/100 enable at 0/25/50 percent
// - Code 110 hands control to enable pin
// - Code 111 uses enable field after full delay
// - Passive discharge on off/reset, optionally when disabled
// - Soft-start bit clear means no limiting
// - Soft-start bit set limits 25mA for 60ms
`timescale 1ns/1ps
`include "lsec_defines.svh"
module lsec_config (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Register port
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// Straps of the sequencing codes and device variant
	input wire logic [2:0] regulator_sequence_select_i,
	input wire logic [2:0] switch_sequence_select_i,
	input wire logic pin_variant_i,
	// Power-on logic status
	input wire logic supply_ok_i,
	input wire logic boot_0_i,
	input wire logic boot_25_i,
	input wire logic boot_50_i,
	input wire logic boot_100_i,
	input wire logic off_entry_i,
	input wire logic hard_reset_entry_i,
	// Pins
	input wire logic regulator_enable_pin_i,
	input wire logic switch_enable_pin_i,
	input wire logic multipurpose_control_pin_i,
	// Regulator controls
	output logic regulator_enable_o,
	output logic regulator_discharge_o,
	output logic regulator_active_discharge_o,
	output logic regulator_load_switch_mode_o,
	// Switch controls
	output logic switch_enable_o,
	output logic switch_current_limit_o
);

	// Writable parts of the two registers
	logic [7:0] ldo_config;
	logic [7:0] load_switch_config;
	// Sequencing codes latched after reset release
	logic [2:0] ldo_seq;
	logic [2:0] sw_seq;
	logic seq_loaded;
	// Soft-start counter and state
	logic [19:0] soft_cnt;
	logic soft_active;
	logic sw_en_q;
	logic next_sw_en;
	// Discharge request one cycle wide per mode entry
	logic dsc_entry;

	// Address match helper, used for both read and write decode
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ref_addr);
		hit = (addr == ref_addr);
	endfunction : hit

	// Straps captured once after reset, never under the asynchronous reset
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ldo_seq <= 3'h0;
			sw_seq <= 3'h0;
			seq_loaded <= 1'b0;
		end else if (!seq_loaded) begin
			ldo_seq <= regulator_sequence_select_i;
			sw_seq <= switch_sequence_select_i;
			seq_loaded <= 1'b1;
		end
	end

	// Register writes; sequencing bits are masked out so writes cannot reach them
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ldo_config <= `LSEC_LDO_RESET;
			load_switch_config <= `LSEC_SW_RESET;
		end else if (reg_wr_i) begin
			if (hit(reg_addr_i, `LSEC_ADDR_LDO_CONFIG)) begin
				ldo_config <= reg_wdata_i & `LSEC_LDO_WMASK;
			end
			if (hit(reg_addr_i, `LSEC_ADDR_LOAD_SWITCH_CONFIG)) begin
				load_switch_config <= reg_wdata_i & `LSEC_SW_WMASK;
			end
		end
	end

	// Read data registered; unmapped addresses and idle cycles read zero
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i && hit(reg_addr_i, `LSEC_ADDR_LDO_CONFIG)) begin
			reg_rdata_o <= {ldo_seq, ldo_config[4:0]};
		end else if (reg_rd_i && hit(reg_addr_i, `LSEC_ADDR_LOAD_SWITCH_CONFIG)) begin
			reg_rdata_o <= {sw_seq, 2'b00, load_switch_config[2:0]};
		end else begin
			reg_rdata_o <= 8'h00;
		end
	end

	// Regulator enable sequencing
	lsec_enable_decode u_ldo_dec (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.seq_i(ldo_seq),
		.en_field_i(ldo_config[`LSEC_LDO_EN_MSB:`LSEC_LDO_EN_LSB]),
		.supply_ok_i(supply_ok_i & seq_loaded),
		.boot_0_i(boot_0_i),
		.boot_25_i(boot_25_i),
		.boot_50_i(boot_50_i),
		.boot_100_i(boot_100_i),
		.pin_en_i(regulator_enable_pin_i),
		.pin_variant_i(pin_variant_i),
		.ctrl_pin_i(multipurpose_control_pin_i),
		.enable_o(regulator_enable_o)
	);

	// Switch enable sequencing, same decode as the regulator
	lsec_enable_decode u_sw_dec (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.seq_i(sw_seq),
		.en_field_i(load_switch_config[`LSEC_SW_EN_MSB:`LSEC_SW_EN_LSB]),
		.supply_ok_i(supply_ok_i & seq_loaded),
		.boot_0_i(boot_0_i),
		.boot_25_i(boot_25_i),
		.boot_50_i(boot_50_i),
		.boot_100_i(boot_100_i),
		.pin_en_i(switch_enable_pin_i),
		.pin_variant_i(pin_variant_i),
		.ctrl_pin_i(multipurpose_control_pin_i),
		.enable_o(next_sw_en)
	);

	// Mode entries are pulses; discharge applies on them regardless of the bit
	assign dsc_entry = off_entry_i | hard_reset_entry_i;

	// Discharge control, registered
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			regulator_discharge_o <= 1'b0;
		end else begin
			regulator_discharge_o <= dsc_entry |
				(ldo_config[`LSEC_LDO_PASDSC_BIT] & !regulator_enable_o);
		end
	end

	// Regulator mode bit follows the register; active discharge follows its bit only while the regulator is off; both from flops
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			regulator_active_discharge_o <= 1'b0;
			regulator_load_switch_mode_o <= 1'b0;
		end else begin
			regulator_active_discharge_o <= ldo_config[`LSEC_LDO_ACTDSC_BIT] & !regulator_enable_o;
			regulator_load_switch_mode_o <= ldo_config[`LSEC_LDO_MODE_BIT];
		end
	end

	// Switch enable pipeline; the rising edge starts the soft-start window
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sw_en_q <= 1'b0;
		end else begin
			sw_en_q <= next_sw_en;
		end
	end

	assign switch_enable_o = sw_en_q;

	// Soft-start timer; a switch turn-off cancels the window early
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			soft_cnt <= 20'h0_0000;
			soft_active <= 1'b0;
		end else if (!next_sw_en) begin
			soft_cnt <= 20'h0_0000;
			soft_active <= 1'b0;
		end else if (next_sw_en && !sw_en_q) begin
			soft_active <= load_switch_config[`LSEC_SW_SOFT_BIT];
			soft_cnt <= 20'(`LSEC_SOFT_START_CYC - 1);
		end else if (soft_active) begin
			if (soft_cnt == 20'h0_0000) begin
				soft_active <= 1'b0;
			end else begin
				soft_cnt <= soft_cnt - 20'h0_0001;
			end
		end
	end

	// Limit output is high while the switch is on inside the window
	assign switch_current_limit_o = soft_active & sw_en_q;

	// Writes never reach the sequencing field
	property p_seq_ro;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		seq_loaded |=> $stable(ldo_seq) && $stable(sw_seq);
	endproperty
	a_seq_ro: assert property (p_seq_ro) else $error("sequencing field changed");

	// Boot 50 percent under code 100 enables on the next cycle
	property p_boot50;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(ldo_seq == 3'h4 && boot_50_i) |=> regulator_enable_o;
	endproperty
	a_boot50: assert property (p_boot50) else $error("regulator not enabled at 50 percent");

	// Pin control only on the pin variant
	property p_pin;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(ldo_seq == 3'h6) |=> (regulator_enable_o == $past(pin_variant_i & regulator_enable_pin_i));
	endproperty
	a_pin: assert property (p_pin) else $error("regulator does not follow enable pin");

	// Mode entry always discharges
	property p_dsc_entry;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		dsc_entry |=> regulator_discharge_o;
	endproperty
	a_dsc_entry: assert property (p_dsc_entry) else $error("no discharge on mode entry");

	// Bit clear with no entry means no discharge, whatever the enable
	property p_dsc_clear;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(!dsc_entry && !ldo_config[`LSEC_LDO_PASDSC_BIT]) |=> !regulator_discharge_o;
	endproperty
	a_dsc_clear: assert property (p_dsc_clear) else $error("discharge with bit clear");

	// Turn-on with soft-start clear has no limit
	property p_no_soft;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(next_sw_en && !sw_en_q && !load_switch_config[`LSEC_SW_SOFT_BIT])
			|=> !switch_current_limit_o;
	endproperty
	a_no_soft: assert property (p_no_soft) else $error("limit without soft-start");

	// Turn-on with soft-start set still limits eight cycles later if the enable holds
	property p_soft;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(next_sw_en && !sw_en_q && load_switch_config[`LSEC_SW_SOFT_BIT])
			##1 next_sw_en [*8] |-> switch_current_limit_o;
	endproperty
	a_soft: assert property (p_soft) else $error("soft-start limit missing");

	// Enable field 01 under code 111 after delay enables
	property p_en_on;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(ldo_seq == 3'h7 && boot_100_i && ldo_config[2:1] == 2'h1) |=> regulator_enable_o;
	endproperty
	a_en_on: assert property (p_en_on) else $error("enable field 01 ignored");

endmodule : lsec_config

// File: tb/lsec_config_tb.sv
// Self-checking bench for the regulator and switch enable configuration block.
// Assumes the design sources under src/ are compiled first; straps change only in reset.
`timescale 1ns/1ps
module testbench;
	// Clock, reset and design inputs, all defined at time zero
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic wr_s = 1'b0, rd_s = 1'b0, var_s = 1'b0, sup = 1'b0, offe = 1'b0, hre = 1'b0;
	logic b0 = 1'b0, b25 = 1'b0, b50 = 1'b0, b100 = 1'b0, lpin = 1'b0, spin = 1'b0, mpin = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, ld, sw;
	logic [2:0] rseq = 3'h0, sseq = 3'h0;
	// Design outputs
	logic [7:0] rdata;
	logic ren, rdis, sen, slim, act, lsw;
	// Expected regulator and switch enables of the current step
	logic er, es;
	// Bench state
	logic [31:0] rng = 32'h0000_0921;
	int err_count = 0;
	int checked = 0;

	// Half-period toggle gives 100 ns
	always #50 clk_sys_i = ~clk_sys_i;

	lsec_config u_dut (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_rdata_o(rdata),
		.regulator_sequence_select_i(rseq), .switch_sequence_select_i(sseq),
		.pin_variant_i(var_s), .supply_ok_i(sup),
		.boot_0_i(b0), .boot_25_i(b25), .boot_50_i(b50), .boot_100_i(b100),
		.off_entry_i(offe), .hard_reset_entry_i(hre),
		.regulator_enable_pin_i(lpin), .switch_enable_pin_i(spin),
		.multipurpose_control_pin_i(mpin),
		.regulator_enable_o(ren), .regulator_discharge_o(rdis),
		.regulator_active_discharge_o(act), .regulator_load_switch_mode_o(lsw),
		.switch_enable_o(sen), .switch_current_limit_o(slim)
	);

	// Pseudo-random source, fixed start so runs repeat
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	// Expected enable from sequencing code, enable field and pin
	function automatic logic exp_en(input logic [2:0] s, input logic [1:0] f, input logic p);
		case (s)
			3'h1: exp_en = sup;
			3'h2: exp_en = b0;
			3'h3: exp_en = b25;
			3'h4: exp_en = b50;
			3'h6: exp_en = var_s & p;
			// Reserved field 11 counts as off
			3'h7: exp_en = b100 & ((f == 2'h1) | ((f == 2'h2) & mpin));
			default: exp_en = 1'b0;
		endcase
	endfunction : exp_en

	// Verdict and end of run, shared with the watchdog
	task automatic end_sim;
		$display("Checks %0d, errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim

	// Compare one byte and count it
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk

	// One write strobe; the next request waits for a fresh edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys_i);
		wr_s <= 1'b0;
	endtask : wr

	// Read strobe; data is registered and valid after the sampling edge
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys_i);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk_sys_i);
		rd_s <= 1'b0;
		#1;
		chk(rdata, e);
	endtask : rd_chk

	// Switch path needs two cycles; four leave margin for discharge too
	task automatic settle;
		repeat (4) @(posedge clk_sys_i);
		#1;
	endtask : settle

	// Random supply, monotonic boot progress and pins
	task automatic rnd_in;
		logic s;
		int l;
		rng = lfsr(rng);
		s = rng[3];
		l = s ? rng[2:0] % 5 : 0;
		@(posedge clk_sys_i);
		sup <= s;
		b0 <= (l > 0);
		b25 <= (l > 1);
		b50 <= (l > 2);
		b100 <= (l > 3);
		lpin <= rng[4];
		spin <= rng[5];
		mpin <= rng[6];
	endtask : rnd_in

	// Watchdog: a hang counts as a mismatch
	initial begin
		repeat (100000) @(posedge clk_sys_i);
		err_count++;
		end_sim;
	end

	// Main sequence: every code on both outputs, one reset per strap set
	initial begin
		for (int c = 0; c < 8; c++) begin
			@(posedge clk_sys_i);
			rst_n_i <= 1'b0;
			rseq <= c[2:0];
			sseq <= 3'(7 - c);
			// Variant high on the regulator's pin code pass, low on the switch's
			var_s <= (c > 3);
			repeat (20) @(posedge clk_sys_i);
			#1;
			// Every control output low while reset is held; read data is not checked
			chk({2'h0, ren, sen, rdis, slim, act, lsw}, 8'h00);
			@(posedge clk_sys_i);
			rst_n_i <= 1'b1;
			for (int t = 0; t < 8; t++) begin
				rnd_in;
				rng = lfsr(rng);
				ld = rng[7:0];
				rng = lfsr(rng);
				sw = rng[15:8];
				wr(8'h0B, ld);
				wr(8'h0C, sw);
				settle;
				er = exp_en(rseq, ld[2:1], lpin);
				es = exp_en(sseq, sw[2:1], spin);
				chk({7'h00, ren}, {7'h00, er});
				chk({7'h00, sen}, {7'h00, es});
				chk({7'h00, rdis}, {7'h00, ld[4] & ~er});
				// Active discharge follows its bit while off; mode bit is a copy
				chk({6'h00, act, lsw}, {6'h00, ld[3] & ~er, ld[0]});
				rd_chk(8'h0B, {rseq, ld[4:0]});
				rd_chk(8'h0C, {sseq, 2'h0, sw[2:0]});
			end
			// Unmapped place reads zero and a write there leaves the regulator register unchanged
			wr(8'h0D, 8'hFF);
			rd_chk(8'h0D, 8'h00);
			rd_chk(8'h0B, {rseq, ld[4:0]});
			if (c == 7) begin
				// Register control after full delay: reserved, control pin, on
				@(posedge clk_sys_i);
				sup <= 1'b1;
				b100 <= 1'b1;
				mpin <= 1'b1;
				for (int k = 3; k > 0; k--) begin
					wr(8'h0B, 8'(k << 1));
					settle;
					chk({7'h00, ren}, {7'h00, k != 3});
				end
				// Field still on, but the full delay is withdrawn
				@(posedge clk_sys_i);
				b100 <= 1'b0;
				settle;
				chk({7'h00, ren}, 8'h00);
			end
			if (c == 0) begin
				// Regulator held off: discharge only from entry pulses
				wr(8'h0B, 8'h00);
				settle;
				chk({7'h00, rdis}, 8'h00);
				for (int k = 0; k < 2; k++) begin
					@(posedge clk_sys_i);
					offe <= (k == 0);
					hre <= (k == 1);
					@(posedge clk_sys_i);
					offe <= 1'b0;
					hre <= 1'b0;
					#1;
					chk({7'h00, rdis}, 8'h01);
				end
				// Switch on code 111 with full delay done
				@(posedge clk_sys_i);
				sup <= 1'b1;
				b100 <= 1'b1;
				wr(8'h0C, 8'h01);
				settle;
				chk({6'h00, sen, slim}, 8'h00);
				wr(8'h0C, 8'h03);
				settle;
				chk({6'h00, sen, slim}, 8'h03);
				// Hold the switch on long enough for the window check to engage
				repeat (8) @(posedge clk_sys_i);
				#1;
				chk({6'h00, sen, slim}, 8'h03);
				wr(8'h0C, 8'h00);
				settle;
				wr(8'h0C, 8'h02);
				settle;
				chk({6'h00, sen, slim}, 8'h02);
			end
		end
		end_sim;
	end
endmodule : testbench
